/* File: src/rss_regs.svh */
`ifndef RSS_REGS_SVH
`define RSS_REGS_SVH
// ----------------------------------------------------------------
// Register offsets (byte addresses, 32-bit words)
// ----------------------------------------------------------------
`define RSS_CTRL_OFF 12'h000
`define RSS_STATUS_OFF 12'h004
`define RSS_DIAG_OFF 12'h008
`define RSS_IRQ_STAT_OFF 12'h00c
`define RSS_IRQ_MASK_OFF 12'h010
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define RSS_CTRL_REMIND_BIT 0
`define RSS_CTRL_STOP_BIT 1
`define RSS_IRQ_ERR_BIT 0
`define RSS_IRQ_WARN_BIT 1
`define RSS_IRQ_STOP_BIT 2
`define RSS_IRQ_RUN_BIT 3
`define RSS_IRQ_W 4
// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RSS_CTRL_RST 1'b0
`define RSS_MASK_RST 4'h0
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define RSS_CLK_HZ 100000000
`define RSS_TMOD_INIT_S 11
`define RSS_BLINK_HALF_MS 250
`define RSS_TMOD_INIT_CYC (`RSS_TMOD_INIT_S * `RSS_CLK_HZ)
`define RSS_BLINK_HALF_CYC (`RSS_BLINK_HALF_MS * (`RSS_CLK_HZ / 1000))
`endif

/* File: src/rss_pkg.sv */
package rss_pkg;
    // Operating mode of the controller
    typedef enum logic [0:0] {
        RSS_STOP = 1'b0,
        RSS_RUN = 1'b1
    } rss_mode_t;
    // Error sources, sampled once per program scan
    typedef struct packed {
        logic module_fault;
        logic config_mismatch;
        logic memory_fail;
        logic project_fault;
    } rss_err_t;
    // Warning sources, sampled once per program scan
    typedef struct packed {
        logic batt_date;
        logic batt_low;
        logic sram_lost;
    } rss_warn_t;
    // Supply state: good wins over low
    typedef struct packed {
        logic good;
        logic low;
    } rss_power_t;
endpackage

/* File: src/rss_supervisor.sv */
// Functional notes
// R1: Switch in run keeps the unit running unless a peripheral stopped it.
// R2: A peripheral stop holds until the switch goes to stop and back to run.
// R3: A stop-to-run switch move requests run, if no error is pending.
// R4: Switch in stop means stop mode and a dark run lamp, also at power-up.
// R5: Power lamp is on when supply is good, blinks when low, else off.
// R6: Run lamp is on in run mode and off in stop mode.
// R7: Run lamp blinks at most 11 s while a temperature module initialises.
// R8: Error lamp on for error, blinking for warning only, else off.
// R9: An error in run mode forces stop mode.
// R10: In stop mode every field output is off.
// R11: An error in stop mode refuses run entry until it clears.
// R12: Warnings neither cause nor block mode changes.
// R13: Warnings are readable status bits; software may request stop.
// R14: Diagnostics are evaluated once per program scan.
// R15: Module, configuration, memory and project faults are errors.
// R16: SRAM loss, low battery and enabled reminder date are warnings.
// R17: Lamps blink from a free-running divider with equal on and off.
//
// Decided for this implementation: register access over APB and the register addresses.
`include "rss_regs.svh"
module rss_supervisor #(
    parameter int unsigned N_OUT = 8,
    parameter int unsigned TMOD_INIT_CYCLES = `RSS_TMOD_INIT_CYC,
    parameter int unsigned BLINK_HALF_CYCLES = `RSS_BLINK_HALF_CYC
) (
    input wire logic sys_clk_in,
    input wire logic reset_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic pready_out,
    output logic [31:0] prdata_out,
    output logic pslverr_out,
    input wire logic mode_switch_run_in,
    input wire logic periph_stop_in,
    input wire logic scan_tick_in,
    input wire rss_pkg::rss_err_t err_src_in,
    input wire rss_pkg::rss_warn_t warn_src_in,
    input wire rss_pkg::rss_power_t power_in,
    input wire logic tmod_present_in,
    input wire logic tmod_ready_in,
    input wire logic [N_OUT-1:0] app_out_in,
    output logic [N_OUT-1:0] field_out,
    output logic run_mode_out,
    output logic power_indicator_out,
    output logic run_indicator_out,
    output logic err_indicator_out,
    output logic irq_out
);
    import rss_pkg::*;

    localparam int unsigned TW = $clog2(TMOD_INIT_CYCLES + 1);
    localparam int unsigned BW = $clog2(BLINK_HALF_CYCLES + 1);

    logic [BW-1:0] blink_cnt;
    logic blink;
    rss_err_t err_q;
    rss_warn_t warn_q;
    logic error_now;
    logic warn_now;
    logic remind_en;
    logic app_stop;
    logic cmd_stop;
    logic sw_q;
    logic sw_rise;
    logic stop_hold;
    rss_mode_t mode;
    rss_mode_t next_mode;
    logic tmod_started;
    logic tmod_init;
    logic [TW-1:0] tmod_cnt;
    logic [3:0] irq_stat;
    logic [3:0] irq_mask;
    logic [3:0] next_irq_stat;
    logic [3:0] irq_ev;
    logic apb_acc;
    logic apb_wr;
    logic addr_hit;
    logic [31:0] rd_word;

    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (reset_in);

    // ----------------------------------------------------------------
    // Blink timebase
    // ----------------------------------------------------------------
    // Free-running so all lamps blink in step
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            blink_cnt <= '0;
            blink <= 1'b0;
        end else if (blink_cnt == BW'(BLINK_HALF_CYCLES - 1)) begin
            blink_cnt <= '0;
            blink <= ~blink; // [R17]
        end else begin
            blink_cnt <= blink_cnt + 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Scan diagnostics
    // ----------------------------------------------------------------
    // Sources are sampled only on the scan strobe, so a glitch between
    // scans never reaches the mode logic
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            err_q <= '0;
            warn_q <= '0;
        end else if (scan_tick_in) begin
            err_q <= err_src_in; // [R14] [R15]
            warn_q.sram_lost <= warn_src_in.sram_lost; // [R16]
            warn_q.batt_low <= warn_src_in.batt_low;
            warn_q.batt_date <= warn_src_in.batt_date & remind_en; // [R16]
        end
    end

    assign error_now = |err_q;
    assign warn_now = |warn_q;

    // Reminder date is gated as it is captured, so turning the enable on
    // later only shows the date from the next scan onward
    scan_update_a: assert property (scan_tick_in |=> // [R14]
        err_q == $past(err_src_in))
        else $error("error state not refreshed on scan");
    remind_gate_a: assert property (scan_tick_in && !remind_en |=> // [R16]
        !warn_q.batt_date)
        else $error("reminder warning raised while disabled");

    // ----------------------------------------------------------------
    // Temperature module start-up
    // ----------------------------------------------------------------
    // Presence is caught one edge after reset release, then the wait ends
    // on ready or on the timeout, whichever comes first
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            tmod_started <= 1'b0;
            tmod_init <= 1'b0;
            tmod_cnt <= '0;
        end else if (!tmod_started) begin
            tmod_started <= 1'b1;
            tmod_init <= tmod_present_in;
        end else if (tmod_init) begin
            if (tmod_ready_in || tmod_cnt == TW'(TMOD_INIT_CYCLES - 1)) begin
                tmod_init <= 1'b0; // [R7]
            end else begin
                tmod_cnt <= tmod_cnt + 1'b1;
            end
        end
    end

    tmod_bound_a: assert property (tmod_init |-> // [R7]
        tmod_cnt < TW'(TMOD_INIT_CYCLES))
        else $error("module start-up blink overran its limit");

    // Ready ends the blink at once; the timeout is only the fallback
    tmod_ready_a: assert property (tmod_init && tmod_ready_in |=> // [R7]
        !tmod_init)
        else $error("module start-up blink outlived ready");

    // ----------------------------------------------------------------
    // Mode control
    // ----------------------------------------------------------------
    assign sw_rise = mode_switch_run_in & ~sw_q;
    assign cmd_stop = periph_stop_in | app_stop;

    // Switch history; reset value of stop makes power-up in run an edge
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            sw_q <= 1'b0;
        end else begin
            sw_q <= mode_switch_run_in;
        end
    end

    // Commanded stop stays visible until the switch passes through stop
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            stop_hold <= 1'b0;
        end else if (!mode_switch_run_in) begin
            stop_hold <= 1'b0; // [R2]
        end else if (cmd_stop) begin
            stop_hold <= 1'b1;
        end
    end

    // Run entry needs a fresh switch edge, so a stop command or an error
    // cannot be undone without touching the switch; warnings play no part
    always_comb begin
        next_mode = mode;
        unique case (mode)
            RSS_STOP: begin
                if (sw_rise && !error_now && !cmd_stop) begin
                    next_mode = RSS_RUN; // [R3] [R11] [R12]
                end
            end
            RSS_RUN: begin
                if (!mode_switch_run_in || cmd_stop || error_now) begin
                    next_mode = RSS_STOP; // [R1] [R2] [R4] [R9]
                end
            end
        endcase
    end

    // Mode and its output copy update together, so the copy never lags
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            mode <= RSS_STOP; // [R4]
            run_mode_out <= 1'b0;
        end else begin
            mode <= next_mode;
            run_mode_out <= (next_mode == RSS_RUN);
        end
    end

    stop_on_switch_a: assert property (!mode_switch_run_in |=> // [R4]
        !run_mode_out)
        else $error("running with switch in stop");
    // The switch must still be in run, else a quick stop-run flip may
    // legally re-enter run
    periph_stop_a: assert property (run_mode_out && periph_stop_in && // [R2]
        mode_switch_run_in |=> !run_mode_out [*2])
        else $error("peripheral stop not honoured");
    run_entry_a: assert property ($rose(run_mode_out) |-> // [R3] [R11]
        $past(mode_switch_run_in && !sw_q && !error_now))
        else $error("run entered without clean switch edge");
    err_stop_a: assert property (run_mode_out && error_now |=> // [R9]
        !run_mode_out)
        else $error("error did not force stop");
    keep_running_a: assert property (run_mode_out && // [R1] [R12]
        mode_switch_run_in && !cmd_stop && !error_now |=> run_mode_out)
        else $error("run mode left without cause");

    // ----------------------------------------------------------------
    // Field outputs
    // ----------------------------------------------------------------
    // Gated by the next mode so outputs drop in the same edge as the mode
    for (genvar i = 0; i < N_OUT; i++) begin : g_out
        always_ff @(posedge sys_clk_in) begin
            if (reset_in) begin
                field_out[i] <= 1'b0;
            end else begin
                field_out[i] <= (next_mode == RSS_RUN) & // [R10]
                    app_out_in[i];
            end
        end
    end

    outputs_off_a: assert property (!run_mode_out |-> // [R10]
        field_out == '0)
        else $error("field output on in stop mode");

    // ----------------------------------------------------------------
    // Indicators
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            power_indicator_out <= 1'b0;
            run_indicator_out <= 1'b0;
            err_indicator_out <= 1'b0;
        end else begin
            power_indicator_out <= power_in.good | // [R5]
                (power_in.low & blink);
            run_indicator_out <= tmod_init ? blink : // [R7]
                (next_mode == RSS_RUN); // [R6]
            err_indicator_out <= error_now | (warn_now & blink); // [R8]
        end
    end

    // Lamp checks allow one register stage after the cause
    power_led_a: assert property (power_in.good |=> // [R5]
        power_indicator_out)
        else $error("power lamp dark with good supply");
    run_led_a: assert property (!$past(tmod_init) |-> // [R6]
        run_indicator_out == run_mode_out)
        else $error("run lamp disagrees with mode");
    err_led_a: assert property (error_now |=> err_indicator_out) // [R8]
        else $error("error lamp dark with error present");
    err_off_a: assert property (!error_now && !warn_now |=> // [R8]
        !err_indicator_out)
        else $error("error lamp lit with no error or warning");

    // ----------------------------------------------------------------
    // Interrupts
    // ----------------------------------------------------------------
    // New error or warning at a scan, and each mode change
    always_comb begin
        irq_ev = '0;
        irq_ev[`RSS_IRQ_ERR_BIT] = scan_tick_in & (|err_src_in) & ~error_now;
        irq_ev[`RSS_IRQ_WARN_BIT] = scan_tick_in & ~warn_now &
            (warn_src_in.sram_lost | warn_src_in.batt_low |
            (warn_src_in.batt_date & remind_en)); // [R13]
        irq_ev[`RSS_IRQ_STOP_BIT] = (mode == RSS_RUN) &&
            (next_mode == RSS_STOP);
        irq_ev[`RSS_IRQ_RUN_BIT] = (mode == RSS_STOP) &&
            (next_mode == RSS_RUN);
    end

    // Set wins over a write-one-to-clear in the same cycle
    always_comb begin
        next_irq_stat = irq_stat;
        if (apb_wr && paddr_in == `RSS_IRQ_STAT_OFF) begin
            next_irq_stat = irq_stat & ~pwdata_in[3:0];
        end
        next_irq_stat = next_irq_stat | irq_ev;
    end

    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            irq_stat <= '0;
            irq_out <= 1'b0;
        end else begin
            irq_stat <= next_irq_stat;
            irq_out <= |(next_irq_stat & irq_mask);
        end
    end

    // Leaving run by the switch must flag the stop event
    stop_irq_a: assert property (run_mode_out && // [R4] [R13]
        !mode_switch_run_in |=> irq_stat[`RSS_IRQ_STOP_BIT])
        else $error("stop entry not flagged");

    // ----------------------------------------------------------------
    // APB slave
    // ----------------------------------------------------------------
    // One wait state: read data is registered so every output is a flop
    assign apb_acc = psel_in & penable_in;
    assign apb_wr = apb_acc & pready_out & pwrite_in;
    assign addr_hit = paddr_in == `RSS_CTRL_OFF ||
        paddr_in == `RSS_STATUS_OFF || paddr_in == `RSS_DIAG_OFF ||
        paddr_in == `RSS_IRQ_STAT_OFF || paddr_in == `RSS_IRQ_MASK_OFF;

    // Decoded from the live address; only the flopped copy reaches
    // the bus, one cycle later
    always_comb begin
        rd_word = '0;
        unique case (paddr_in)
            `RSS_CTRL_OFF: rd_word[`RSS_CTRL_REMIND_BIT] = remind_en;
            `RSS_STATUS_OFF: rd_word[5:0] = {stop_hold, mode_switch_run_in,
                tmod_init, warn_now, error_now, mode == RSS_RUN}; // [R13]
            `RSS_DIAG_OFF: rd_word[6:0] = {warn_q, err_q}; // [R13]
            `RSS_IRQ_STAT_OFF: rd_word[3:0] = irq_stat;
            `RSS_IRQ_MASK_OFF: rd_word[3:0] = irq_mask;
            default: rd_word = '0;
        endcase
    end

    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            pready_out <= 1'b0;
            prdata_out <= '0;
            pslverr_out <= 1'b0;
        end else begin
            pready_out <= apb_acc & ~pready_out;
            prdata_out <= (apb_acc && !pready_out && !pwrite_in) ?
                rd_word : '0;
            pslverr_out <= apb_acc & ~pready_out & ~addr_hit;
        end
    end

    // Control and mask writes; stop request is a one-cycle pulse
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            remind_en <= `RSS_CTRL_RST;
            irq_mask <= `RSS_MASK_RST;
            app_stop <= 1'b0;
        end else begin
            app_stop <= apb_wr && paddr_in == `RSS_CTRL_OFF &&
                pwdata_in[`RSS_CTRL_STOP_BIT]; // [R13]
            if (apb_wr && paddr_in == `RSS_CTRL_OFF) begin
                remind_en <= pwdata_in[`RSS_CTRL_REMIND_BIT];
            end
            if (apb_wr && paddr_in == `RSS_IRQ_MASK_OFF) begin
                irq_mask <= pwdata_in[3:0];
            end
        end
    end

    // A software stop acts within one cycle, just as a port stop does
    app_stop_a: assert property (app_stop && run_mode_out |=> // [R13]
        !run_mode_out)
        else $error("software stop not honoured");
endmodule

/* File: bench/rss_panel_model.sv */
module rss_panel_model #(
    parameter int SCAN_CYC = 8
) (
    input wire logic sys_clk_in,
    input wire logic reset_in,
    input wire logic stop_req_in,
    output logic scan_tick_out,
    output logic periph_stop_out
);
    timeunit 1ns;
    timeprecision 1ns;
    int scan_cnt;
    // Program scan: a single tick closes every scan, never two at once
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            scan_cnt <= 0;
            scan_tick_out <= 1'b0;
        end else begin
            scan_cnt <= (scan_cnt == SCAN_CYC - 1) ? 0 : scan_cnt + 1;
            scan_tick_out <= (scan_cnt == SCAN_CYC - 1);
        end
    end
    // Peripheral stop: one pulse per request, as a port command would be
    always_ff @(posedge sys_clk_in) begin
        periph_stop_out <= reset_in ? 1'b0 : stop_req_in;
    end
endmodule

/* File: bench/tb_run_stop_mode_status_indicator.sv */
`define CHK(nm, e, o) begin n_tests++; if ((o) !== (e)) begin n_errors++; \
    $display("mismatch %s expected %h seen %h", nm, e, o); end end
module tb_run_stop_mode_status_indicator;
    timeunit 1ns;
    timeprecision 1ns;
    import rss_pkg::*;
    localparam int SCAN = 8;
    typedef struct {string nm; logic [32:0] e; logic [32:0] m;
        int s;} rss_note_t;
    logic sys_clk_in, reset_in, psel_in, penable_in, pwrite_in;
    logic [11:0] paddr_in;
    logic [31:0] pwdata_in, prdata_out;
    logic pready_out, pslverr_out, mode_switch_run_in, periph_stop_in;
    logic scan_tick_in, tmod_present_in, tmod_ready_in, stop_req, probe;
    rss_err_t err_src_in;
    rss_warn_t warn_src_in;
    rss_power_t power_in;
    logic [7:0] app_out_in, field_out;
    logic run_mode_out, power_indicator_out, run_indicator_out;
    logic err_indicator_out, irq_out;
    int n_errors, n_tests, meas;
    rss_note_t notes[$];
    logic [1:0] pw[4] = '{2'b10, 2'b01, 2'b00, 2'b11};
    int pc[4] = '{16, 8, 0, 16};
    wire [12:0] snap = {field_out, run_mode_out, power_indicator_out,
        run_indicator_out, err_indicator_out, irq_out};

    rss_supervisor #(.N_OUT(8), .TMOD_INIT_CYCLES(200),
        .BLINK_HALF_CYCLES(4)) DUT (.sys_clk_in, .reset_in, .psel_in,
        .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .pready_out,
        .prdata_out, .pslverr_out, .mode_switch_run_in, .periph_stop_in,
        .scan_tick_in, .err_src_in, .warn_src_in, .power_in,
        .tmod_present_in, .tmod_ready_in, .app_out_in, .field_out,
        .run_mode_out, .power_indicator_out, .run_indicator_out,
        .err_indicator_out, .irq_out);
    rss_panel_model #(.SCAN_CYC(SCAN)) partner (.sys_clk_in, .reset_in,
        .stop_req_in(stop_req), .scan_tick_out(scan_tick_in),
        .periph_stop_out(periph_stop_in));

    // Clock
    initial begin
        sys_clk_in = 1'b0;
        forever #5 sys_clk_in = ~sys_clk_in;
    end
    // Watcher: oldest note against whatever result shows up now
    always @(posedge sys_clk_in) begin
        rss_note_t q;
        logic [32:0] obs;
        if ((psel_in && penable_in && pready_out === 1'b1 && !pwrite_in
                || probe) && notes.size() > 0) begin
            q = notes.pop_front();
            obs = q.s == 0 ? {pslverr_out, prdata_out} :
                q.s == 1 ? 33'(snap) : 33'(meas);
            `CHK(q.nm, q.e & q.m, obs & q.m)
        end
    end
    // ----------------------------------------------------------------
    // Drivers
    // ----------------------------------------------------------------
    task automatic apb(input logic wr, input logic [11:0] a,
            input logic [31:0] d);
        @(posedge sys_clk_in);
        psel_in <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in <= wr;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge sys_clk_in);
        penable_in <= 1'b1;
        // Only the watchdog may end this wait
        do begin
            @(posedge sys_clk_in);
        end while (pready_out !== 1'b1);
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask
    task automatic rd(input string nm, input logic [11:0] a,
            input logic [31:0] e, m);
        notes.push_back('{nm, {1'b0, e}, {1'b1, m}, 0});
        apb(1'b0, a, 32'h0);
    endtask
    // Port probe; the watcher compares on the edge after probe rises
    task automatic note(input string nm, input logic [32:0] e, m, int s);
        notes.push_back('{nm, e, m, s});
        @(posedge sys_clk_in) probe <= 1'b1;
        @(posedge sys_clk_in) probe <= 1'b0;
    endtask
    task automatic mode(input string nm, input logic r);
        note(nm, r ? {20'h0, app_out_in, 5'b10100} : 33'h0, 33'h1ff4, 1);
    endtask
    // Two blink periods hold exactly 16 samples, 8 high, in any phase
    task automatic lamp(input string nm, input int b, input int e);
        meas = 0;
        repeat (16) begin
            @(posedge sys_clk_in);
            meas += snap[b];
        end
        note(nm, 33'(e), '1, 2);
    endtask
    task automatic sw(input logic v);
        @(posedge sys_clk_in) mode_switch_run_in <= v;
        repeat (4) @(posedge sys_clk_in);
    endtask
    task automatic scan();
        repeat (SCAN + 4) @(posedge sys_clk_in);
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Watchdog: whole run is about a thousand cycles
    initial begin
        repeat (20000) @(posedge sys_clk_in);
        n_errors++;
        $display("watchdog expired");
        end_of_test();
    end
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} = '0;
        {mode_switch_run_in, tmod_present_in, tmod_ready_in} = '0;
        {stop_req, probe, err_src_in, warn_src_in} = '0;
        power_in = 2'b10;
        reset_in = 1'b1;
        void'($urandom(39615));
        app_out_in = 8'($urandom);
        repeat (3) @(posedge sys_clk_in);
        reset_in <= 1'b0;
        repeat (3) @(posedge sys_clk_in);
        note("reset ports", 33'h8, '1, 1);
        rd("ctrl reset", 12'h000, 32'h0, '1);
        rd("mask reset", 12'h010, 32'h0, '1);
        notes.push_back('{"unmapped", 33'h100000000, '1, 0});
        apb(1'b0, 12'h014, 32'h0);
        $display("reset test done");
        sw(1'b1);
        mode("run entry", 1'b1);
        rd("status run", 12'h004, 32'h11, 32'h3f);
        rd("irq run", 12'h00c, 32'h8, 32'h8);
        apb(1'b1, 12'h00c, 32'hf);
        rd("irq clear", 12'h00c, 32'h0, 32'hf);
        repeat (3) begin
            app_out_in <= 8'($urandom);
            repeat (3) @(posedge sys_clk_in);
            mode("image", 1'b1);
        end
        $display("run test done");
        @(posedge sys_clk_in) stop_req <= 1'b1;
        @(posedge sys_clk_in) stop_req <= 1'b0;
        repeat (4) @(posedge sys_clk_in);
        mode("periph stop", 1'b0);
        repeat (20) @(posedge sys_clk_in);
        rd("stop hold", 12'h004, 32'h20, 32'h21);
        sw(1'b0);
        sw(1'b1);
        mode("rerun", 1'b1);
        apb(1'b1, 12'h000, 32'h2);
        repeat (3) @(posedge sys_clk_in);
        mode("soft stop", 1'b0);
        sw(1'b0);
        sw(1'b1);
        $display("stop test done");
        apb(1'b1, 12'h010, 32'h2);
        for (int i = 0; i < 3; i++) begin
            warn_src_in <= 3'(1 << i);
            scan();
            rd("warn status", 12'h004, i < 2 ? 32'h5 : 32'h1,
                32'h5);
            if (i < 2) lamp("warn lamp", 1, 8);
        end
        apb(1'b1, 12'h000, 32'h1);
        scan();
        rd("remind", 12'h004, 32'h5, 32'h5);
        rd("diag", 12'h008, 32'h40, 32'h7f);
        note("irq on", 33'h1, 33'h1, 1);
        apb(1'b1, 12'h010, 32'h0);
        note("irq masked", 33'h0, 33'h1, 1);
        apb(1'b1, 12'h00c, 32'hf);
        apb(1'b1, 12'h010, 32'h2);
        note("irq cleared", 33'h0, 33'h1, 1);
        warn_src_in <= '0;
        apb(1'b1, 12'h000, 32'h0);
        scan();
        lamp("lamp off", 1, 0);
        $display("warning test done");
        for (int i = 0; i < 4; i++) begin
            err_src_in <= 4'(1 << i);
            scan();
            mode("err stop", 1'b0);
            if (i == 0) rd("irq err", 12'h00c, 32'h5, 32'h5);
            lamp("err lamp", 1, 16);
            err_src_in <= '0;
            scan();
            mode("no rerun", 1'b0);
            sw(1'b0);
            sw(1'b1);
            mode("err rerun", 1'b1);
        end
        sw(1'b0);
        err_src_in <= 4'h2;
        scan();
        sw(1'b1);
        mode("refuse", 1'b0);
        err_src_in <= '0;
        scan();
        sw(1'b0);
        sw(1'b1);
        mode("cleared", 1'b1);
        $display("error test done");
        for (int i = 0; i < 4; i++) begin
            power_in <= pw[i];
            repeat (2) @(posedge sys_clk_in);
            lamp("power lamp", 3, pc[i]);
        end
        $display("power test done");
        tmod_present_in <= 1'b1;
        reset_in <= 1'b1;
        repeat (3) @(posedge sys_clk_in);
        reset_in <= 1'b0;
        repeat (4) @(posedge sys_clk_in);
        lamp("tmod blink", 2, 8);
        repeat (200) @(posedge sys_clk_in);
        lamp("tmod end", 2, 16);
        tmod_ready_in <= 1'b1;
        reset_in <= 1'b1;
        repeat (3) @(posedge sys_clk_in);
        reset_in <= 1'b0;
        repeat (4) @(posedge sys_clk_in);
        lamp("tmod ready", 2, 16);
        $display("module init test done");
        end_of_test();
    end
endmodule
